// *** hw/operand_address_generator.sv ***
// instruction sequencer with operand effective-address formation
`include "opgen_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator
	import opgen_pkg::*;
#(
	parameter int AW = `ADDR_W,
	parameter int DW = `BYTE_W
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic start_i,
	input wire opgen_pkg::op_t op_i,
	input wire opgen_pkg::addr_mode_t mode_i,
	input wire logic [DW-1:0] branch_offset_i,
	input wire logic [DW-1:0] mem_rdata_i,
	input wire logic mem_ready_i,
	output logic busy_o,
	output logic done_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [AW-1:0] mem_addr_o,
	output logic [DW-1:0] mem_wdata_o,
	output logic [AW-1:0] pc_o,
	output logic [AW-1:0] ea_o,
	output logic [DW-1:0] acc_o,
	output logic [DW-1:0] x_o,
	output logic [DW-1:0] y_o,
	output logic [DW-1:0] sp_o,
	output logic [DW-1:0] flags_o
);
	import opgen_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	state_t state_reg, state_next;
	op_t op_reg;
	addr_mode_t mode_reg;
	logic [DW-1:0] lo_reg, operand_reg, acc_reg, x_reg, y_reg, sp_reg, p_reg;
	logic [AW-1:0] pc_reg, ea_reg, addr_reg;
	logic [DW-1:0] wdata_reg;
	logic req_reg, we_reg, done_reg;
	logic [DW-1:0] rdata_s1, rdata_s2;
	logic ready_s1, ready_s2;
	logic ready_s3, ready_ack;

	// memory answers come from the pins, so two flops before use
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rdata_s1 <= `ZERO_BYTE;
			rdata_s2 <= `ZERO_BYTE;
			ready_s1 <= 1'b0;
			ready_s2 <= 1'b0;
			ready_s3 <= 1'b0;
		end else if (clk_en_i) begin
			rdata_s1 <= mem_rdata_i;
			rdata_s2 <= rdata_s1;
			ready_s1 <= mem_ready_i;
			ready_s2 <= ready_s1;
			ready_s3 <= ready_s2;
		end
	end
	// ready is a level that lingers two cycles after the request moves,
	// so only its rising edge completes an access
	assign ready_ack = ready_s2 && !ready_s3;

	////////////////////////////////////////////////////////////////////////
	// address arithmetic
	logic [DW-1:0] index_val;
	logic [DW:0] low_sum;
	logic [AW-1:0] ea_calc;
	logic is_indexed_x;
	logic two_bytes, one_byte, needs_read, needs_write, is_rmw, writes_back;

	assign is_indexed_x = (mode_reg == mode_zero_page_x || mode_reg == mode_absolute_x);
	assign index_val = is_indexed_x ? x_reg : y_reg;
	// low-byte add keeps its carry for the absolute indexed case
	assign low_sum = {1'b0, lo_reg} + {1'b0, index_val};
	always_comb begin
		case (mode_reg)
			mode_absolute: ea_calc = {rdata_s2, lo_reg};
			mode_zero_page: ea_calc = {`ZERO_BYTE, lo_reg};
			mode_zero_page_x, mode_zero_page_y:
				ea_calc = {`ZERO_BYTE, low_sum[DW-1:0]};
			mode_absolute_x, mode_absolute_y:
				ea_calc = {rdata_s2 + {{(DW-1){1'b0}}, low_sum[DW]}, low_sum[DW-1:0]};
			default: ea_calc = `ZERO_ADDR;
		endcase
	end

	// implied, accumulator and immediate forms take no address bytes
	assign two_bytes = (mode_reg == mode_absolute || mode_reg == mode_absolute_x ||
		mode_reg == mode_absolute_y);
	assign one_byte = (mode_reg == mode_zero_page || mode_reg == mode_zero_page_x ||
		mode_reg == mode_zero_page_y);
	assign needs_write = (op_reg == op_store_accumulator || op_reg == op_store_x ||
		op_reg == op_store_y);
	assign is_rmw = (op_reg == op_shift_left || op_reg == op_shift_right ||
		op_reg == op_rotate_left || op_reg == op_rotate_right ||
		op_reg == op_memory_plus_one || op_reg == op_memory_minus_one);
	assign needs_read = !needs_write && (op_reg != op_jump) && (one_byte || two_bytes);
	assign writes_back = is_rmw && (one_byte || two_bytes);

	////////////////////////////////////////////////////////////////////////
	// alu
	logic [DW-1:0] alu_a, alu_b, alu_res;
	logic alu_c, alu_v;
	always_comb begin
		case (op_reg)
			op_compare_x: alu_a = x_reg;
			op_compare_y: alu_a = y_reg;
			default: alu_a = acc_reg;
		endcase
		case (op_reg)
			op_x_plus_one, op_x_minus_one: alu_b = x_reg;
			op_y_plus_one, op_y_minus_one: alu_b = y_reg;
			default: alu_b = (mode_reg == mode_accumulator) ? acc_reg : operand_reg;
		endcase
	end
	operand_alu #(.WIDTH(DW)) alu_u (
		.op_i(op_reg),
		.a_i(alu_a),
		.b_i(alu_b),
		.carry_i(p_reg[`FLAG_C]),
		.decimal_i(p_reg[`FLAG_D]),
		.result_o(alu_res),
		.carry_o(alu_c),
		.overflow_o(alu_v)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_idle: if (start_i) begin
				state_next = st_fetch_lo;
			end
			st_fetch_lo: if (mode_reg == mode_immediate || one_byte || two_bytes) begin
				if (ready_ack) begin
					state_next = two_bytes ? st_fetch_hi : (needs_read ? st_mem_read :
						(needs_write ? st_write : st_execute));
				end
			end else begin
				state_next = st_execute;
			end
			st_fetch_hi: if (ready_ack) begin
				state_next = needs_read ? st_mem_read : (needs_write ? st_write : st_execute);
			end
			st_mem_read: if (ready_ack) begin
				state_next = st_execute;
			end
			st_execute: state_next = writes_back ? st_write : st_idle;
			st_write: if (ready_ack) begin
				state_next = st_idle;
			end
			default: state_next = st_idle;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg <= st_idle;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	// latch the decoded instruction at start
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			op_reg <= op_idle_instruction;
			mode_reg <= mode_implied;
		end else if (clk_en_i && state_reg == st_idle && start_i) begin
			op_reg <= op_i;
			mode_reg <= mode_i;
		end
	end

	// operand bytes and effective address capture
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			lo_reg <= `ZERO_BYTE;
			operand_reg <= `ZERO_BYTE;
			ea_reg <= `ZERO_ADDR;
		end else if (clk_en_i && ready_ack) begin
			if (state_reg == st_fetch_lo) begin
				lo_reg <= rdata_s2;
				if (mode_reg == mode_immediate) begin
					operand_reg <= rdata_s2;
				end else if (one_byte) begin
					ea_reg <= mode_reg == mode_zero_page ? {`ZERO_BYTE, rdata_s2} :
						{`ZERO_BYTE, rdata_s2 + index_val};
				end
			end else if (state_reg == st_fetch_hi) begin
				ea_reg <= ea_calc;
			end else if (state_reg == st_mem_read) begin
				operand_reg <= rdata_s2;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory request port: one request per access, held until ready
	logic [AW-1:0] next_addr;
	always_comb begin
		case (state_next)
			st_fetch_lo, st_fetch_hi: next_addr = (state_reg == st_idle) ? pc_reg :
				pc_reg + {{(AW-1){1'b0}}, 1'b1};
			st_mem_read, st_write: next_addr = (state_reg == st_fetch_hi) ? ea_calc : ea_reg;
			default: next_addr = addr_reg;
		endcase
		if (state_reg == st_fetch_lo && state_next != st_fetch_hi && one_byte) begin
			next_addr = (mode_reg == mode_zero_page) ? {`ZERO_BYTE, rdata_s2} :
				{`ZERO_BYTE, rdata_s2 + index_val};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= `ZERO_ADDR;
		end else if (clk_en_i) begin
			if (state_next != state_reg || (state_reg == st_fetch_lo && ready_ack &&
				state_next == st_fetch_lo)) begin
				// at the start edge mode_reg is still stale, so decode mode_i there
				req_reg <= (state_next == st_fetch_lo && (state_reg == st_idle ?
					!(mode_i inside {mode_implied, mode_accumulator}) :
					(mode_reg == mode_immediate || one_byte || two_bytes))) ||
					state_next == st_fetch_hi || state_next == st_mem_read ||
					state_next == st_write;
				we_reg <= state_next == st_write;
				addr_reg <= next_addr;
			end else if (ready_ack) begin
				req_reg <= 1'b0;
			end
		end
	end

	// store data or the modified value for read-modify-write
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wdata_reg <= `ZERO_BYTE;
		end else if (clk_en_i && state_next == st_write) begin
			case (op_reg)
				op_store_accumulator: wdata_reg <= acc_reg;
				op_store_x: wdata_reg <= x_reg;
				op_store_y: wdata_reg <= y_reg;
				default: wdata_reg <= alu_res;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execute: registers, flags, program counter
	logic branch_taken;
	always_comb begin
		case (op_reg)
			op_branch_if_carry_clear: branch_taken = !p_reg[`FLAG_C];
			op_branch_if_carry_set: branch_taken = p_reg[`FLAG_C];
			op_branch_if_zero: branch_taken = p_reg[`FLAG_Z];
			op_branch_if_nonzero: branch_taken = !p_reg[`FLAG_Z];
			op_branch_if_negative: branch_taken = p_reg[`FLAG_N];
			op_branch_if_positive: branch_taken = !p_reg[`FLAG_N];
			op_branch_if_overflow_clear: branch_taken = !p_reg[`FLAG_V];
			op_branch_if_overflow_set: branch_taken = p_reg[`FLAG_V];
			default: branch_taken = 1'b0;
		endcase
	end

	logic exec;
	assign exec = clk_en_i && state_reg == st_execute;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			acc_reg <= `ZERO_BYTE;
			x_reg <= `ZERO_BYTE;
			y_reg <= `ZERO_BYTE;
			sp_reg <= `RESET_SP;
		end else if (exec) begin
			case (op_reg)
				op_add_with_carry, op_subtract_with_borrow, op_bitwise_and,
				op_bitwise_or, op_bitwise_xor: acc_reg <= alu_res;
				op_shift_left, op_shift_right, op_rotate_left, op_rotate_right:
					if (mode_reg == mode_accumulator) begin
						acc_reg <= alu_res;
					end
				op_load_accumulator: acc_reg <= operand_reg;
				op_load_x: x_reg <= operand_reg;
				op_load_y: y_reg <= operand_reg;
				op_x_plus_one, op_x_minus_one: x_reg <= alu_res;
				op_y_plus_one, op_y_minus_one: y_reg <= alu_res;
				op_copy_acc_to_x: x_reg <= acc_reg;
				op_copy_acc_to_y: y_reg <= acc_reg;
				op_copy_sp_to_x: x_reg <= sp_reg;
				op_copy_x_to_acc: acc_reg <= x_reg;
				op_copy_x_to_sp: sp_reg <= x_reg;
				op_copy_y_to_acc: acc_reg <= y_reg;
				// stack is kept as pointer movement only; data lives off-block
				op_push_accumulator, op_push_flags: sp_reg <= sp_reg - 8'h01;
				op_pull_accumulator, op_pull_flags: sp_reg <= sp_reg + 8'h01;
				default: begin
				end
			endcase
		end
	end

	// flag updates; compares never write the compared register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			p_reg <= `RESET_FLAGS;
		end else if (exec) begin
			case (op_reg)
				op_clear_carry: p_reg[`FLAG_C] <= 1'b0;
				op_clear_decimal: p_reg[`FLAG_D] <= 1'b0;
				op_clear_irq_mask: p_reg[`FLAG_I] <= 1'b0;
				op_clear_overflow: p_reg[`FLAG_V] <= 1'b0;
				op_set_carry: p_reg[`FLAG_C] <= 1'b1;
				op_set_decimal: p_reg[`FLAG_D] <= 1'b1;
				op_set_irq_mask, op_software_break: p_reg[`FLAG_I] <= 1'b1;
				op_add_with_carry, op_subtract_with_borrow: begin
					p_reg[`FLAG_C] <= alu_c;
					p_reg[`FLAG_V] <= alu_v;
					p_reg[`FLAG_Z] <= alu_res == `ZERO_BYTE;
					p_reg[`FLAG_N] <= alu_res[DW-1];
				end
				op_compare_acc, op_compare_x, op_compare_y: begin
					p_reg[`FLAG_C] <= alu_c;
					p_reg[`FLAG_Z] <= alu_res == `ZERO_BYTE;
					p_reg[`FLAG_N] <= alu_res[DW-1];
				end
				op_bit_test: begin
					p_reg[`FLAG_Z] <= alu_res == `ZERO_BYTE;
					p_reg[`FLAG_V] <= operand_reg[DW-2];
					p_reg[`FLAG_N] <= operand_reg[DW-1];
				end
				op_shift_left, op_shift_right, op_rotate_left, op_rotate_right: begin
					p_reg[`FLAG_C] <= alu_c;
					p_reg[`FLAG_Z] <= alu_res == `ZERO_BYTE;
					p_reg[`FLAG_N] <= alu_res[DW-1];
				end
				op_load_accumulator, op_load_x, op_load_y: begin
					p_reg[`FLAG_Z] <= operand_reg == `ZERO_BYTE;
					p_reg[`FLAG_N] <= operand_reg[DW-1];
				end
				op_pull_flags: p_reg <= operand_reg;
				op_bitwise_and, op_bitwise_or, op_bitwise_xor, op_memory_plus_one,
				op_memory_minus_one, op_x_plus_one, op_x_minus_one, op_y_plus_one,
				op_y_minus_one: begin
					p_reg[`FLAG_Z] <= alu_res == `ZERO_BYTE;
					p_reg[`FLAG_N] <= alu_res[DW-1];
				end
				default: begin
				end
			endcase
		end
	end

	// program counter: past the consumed bytes, or redirected
	logic [1:0] inst_len;
	assign inst_len = two_bytes ? 2'd3 : ((one_byte || mode_reg == mode_immediate) ?
		2'd2 : 2'd1);
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pc_reg <= `ZERO_ADDR;
		end else if (exec) begin
			case (op_reg)
				op_jump, op_call_subroutine: pc_reg <= ea_reg;
				op_software_break: pc_reg <= `BRK_VECTOR_LO;
				default: pc_reg <= pc_reg + {{(AW-2){1'b0}}, inst_len} +
					(branch_taken ? {{(AW-DW){branch_offset_i[DW-1]}}, branch_offset_i}
					: `ZERO_ADDR);
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			done_reg <= 1'b0;
		end else if (clk_en_i) begin
			done_reg <= state_reg != st_idle && state_next == st_idle;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign busy_o = state_reg != st_idle;
	assign done_o = done_reg;
	assign mem_req_o = req_reg;
	assign mem_we_o = we_reg;
	assign mem_addr_o = addr_reg;
	assign mem_wdata_o = wdata_reg;
	assign pc_o = pc_reg;
	assign ea_o = ea_reg;
	assign acc_o = acc_reg;
	assign x_o = x_reg;
	assign y_o = y_reg;
	assign sp_o = sp_reg;
	assign flags_o = p_reg;
endmodule
`default_nettype wire

// *** hw/operand_alu.sv ***
// arithmetic and logic unit for one instruction step
`timescale 1ns/10ps
`default_nettype none
module operand_alu
	import opgen_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire opgen_pkg::op_t op_i,
	input wire logic [WIDTH-1:0] a_i,
	input wire logic [WIDTH-1:0] b_i,
	input wire logic carry_i,
	input wire logic decimal_i,
	output logic [WIDTH-1:0] result_o,
	output logic carry_o,
	output logic overflow_o
);
	logic [WIDTH:0] sum;
	logic [WIDTH-1:0] addend;
	// subtraction adds the complement; decimal correction is not modelled
	always_comb begin
		addend = (op_i == op_subtract_with_borrow || op_i == op_compare_acc ||
			op_i == op_compare_x || op_i == op_compare_y) ? ~b_i : b_i;
		sum = {1'b0, a_i} + {1'b0, addend} +
			{{WIDTH{1'b0}}, (op_i == op_add_with_carry || op_i == op_subtract_with_borrow)
			? carry_i : 1'b1};
		result_o = sum[WIDTH-1:0];
		carry_o = sum[WIDTH];
		overflow_o = (a_i[WIDTH-1] == addend[WIDTH-1]) && (sum[WIDTH-1] != a_i[WIDTH-1]);
		case (op_i)
			op_add_with_carry, op_subtract_with_borrow: begin
			end
			op_compare_acc, op_compare_x, op_compare_y: begin
				overflow_o = 1'b0;
			end
			op_bitwise_and, op_bit_test: begin
				result_o = a_i & b_i;
				carry_o = carry_i;
				overflow_o = b_i[WIDTH-2];
			end
			op_bitwise_or: begin
				result_o = a_i | b_i;
				carry_o = carry_i;
				overflow_o = 1'b0;
			end
			op_bitwise_xor: begin
				result_o = a_i ^ b_i;
				carry_o = carry_i;
				overflow_o = 1'b0;
			end
			op_shift_left, op_rotate_left: begin
				result_o = {b_i[WIDTH-2:0], (op_i == op_rotate_left) ? carry_i : 1'b0};
				carry_o = b_i[WIDTH-1];
				overflow_o = 1'b0;
			end
			op_shift_right, op_rotate_right: begin
				result_o = {(op_i == op_rotate_right) ? carry_i : 1'b0, b_i[WIDTH-1:1]};
				carry_o = b_i[0];
				overflow_o = 1'b0;
			end
			op_memory_plus_one, op_x_plus_one, op_y_plus_one: begin
				result_o = b_i + {{(WIDTH-1){1'b0}}, 1'b1};
				carry_o = carry_i;
				overflow_o = 1'b0;
			end
			op_memory_minus_one, op_x_minus_one, op_y_minus_one: begin
				result_o = b_i - {{(WIDTH-1){1'b0}}, 1'b1};
				carry_o = carry_i;
				overflow_o = 1'b0;
			end
			default: begin
				result_o = b_i;
				carry_o = carry_i;
				overflow_o = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// *** hw/opgen_consts.svh ***
// constant definitions for the operand address generator
`ifndef OPGEN_CONSTS_SVH
`define OPGEN_CONSTS_SVH
`define ADDR_W 16
`define BYTE_W 8
`define ZERO_BYTE 8'h00
`define ZERO_ADDR 16'h0000
`define STACK_PAGE 8'h01
`define RESET_SP 8'hFD
`define RESET_FLAGS 8'h24
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_I 2
`define FLAG_D 3
`define FLAG_B 4
`define FLAG_V 6
`define FLAG_N 7
`define BRK_VECTOR_LO 16'hFFFE
`endif

// *** hw/opgen_pkg.sv ***
// types shared by the operand address generator files
package opgen_pkg;
	typedef enum logic [3:0] {
		mode_implied = 4'h0,
		mode_accumulator = 4'h1,
		mode_immediate = 4'h2,
		mode_absolute = 4'h3,
		mode_zero_page = 4'h4,
		mode_zero_page_x = 4'h5,
		mode_zero_page_y = 4'h6,
		mode_absolute_x = 4'h7,
		mode_absolute_y = 4'h8
	} addr_mode_t;
	typedef enum logic [5:0] {
		op_add_with_carry = 6'h00, op_subtract_with_borrow = 6'h01,
		op_bitwise_and = 6'h02, op_bitwise_or = 6'h03, op_bitwise_xor = 6'h04,
		op_bit_test = 6'h05, op_shift_left = 6'h06, op_shift_right = 6'h07,
		op_rotate_left = 6'h08, op_rotate_right = 6'h09,
		op_compare_acc = 6'h0A, op_compare_x = 6'h0B, op_compare_y = 6'h0C,
		op_load_accumulator = 6'h0D, op_load_x = 6'h0E, op_load_y = 6'h0F,
		op_store_accumulator = 6'h10, op_store_x = 6'h11, op_store_y = 6'h12,
		op_memory_plus_one = 6'h13, op_memory_minus_one = 6'h14,
		op_x_plus_one = 6'h15, op_y_plus_one = 6'h16,
		op_x_minus_one = 6'h17, op_y_minus_one = 6'h18,
		op_copy_acc_to_x = 6'h19, op_copy_acc_to_y = 6'h1A, op_copy_sp_to_x = 6'h1B,
		op_copy_x_to_acc = 6'h1C, op_copy_x_to_sp = 6'h1D, op_copy_y_to_acc = 6'h1E,
		op_clear_carry = 6'h1F, op_clear_decimal = 6'h20, op_clear_irq_mask = 6'h21,
		op_clear_overflow = 6'h22, op_set_carry = 6'h23, op_set_decimal = 6'h24,
		op_set_irq_mask = 6'h25,
		op_push_accumulator = 6'h26, op_push_flags = 6'h27,
		op_pull_accumulator = 6'h28, op_pull_flags = 6'h29,
		op_branch_if_carry_clear = 6'h2A, op_branch_if_carry_set = 6'h2B,
		op_branch_if_zero = 6'h2C, op_branch_if_nonzero = 6'h2D,
		op_branch_if_negative = 6'h2E, op_branch_if_positive = 6'h2F,
		op_branch_if_overflow_clear = 6'h30, op_branch_if_overflow_set = 6'h31,
		op_jump = 6'h32, op_call_subroutine = 6'h33, op_subroutine_return = 6'h34,
		op_interrupt_return = 6'h35, op_software_break = 6'h36,
		op_idle_instruction = 6'h37
	} op_t;
	typedef enum logic [5:0] {
		st_idle = 6'b000001,
		st_fetch_lo = 6'b000010,
		st_fetch_hi = 6'b000100,
		st_mem_read = 6'b001000,
		st_execute = 6'b010000,
		st_write = 6'b100000
	} state_t;
endpackage

// *** tb/opgen_asserts.sv ***
// concurrent checks on the operand address generator ports
`timescale 1ns/10ps
`default_nettype none
module opgen_asserts
	import opgen_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic start_i,
	input wire opgen_pkg::op_t op_i,
	input wire opgen_pkg::addr_mode_t mode_i,
	input wire logic mem_ready_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic [15:0] pc_o,
	input wire logic [7:0] acc_o,
	input wire logic [7:0] x_o,
	input wire logic [7:0] y_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic take;
	op_t op_q;
	addr_mode_t mode_q;
	logic [15:0] pc_q;
	logic [23:0] regs_q;
	// op and mode are sampled only at the accepting edge, so keep a copy
	assign take = clk_en_i && start_i && !busy_o;
	always_ff @(posedge core_clk_i) begin
		if (take) begin
			op_q <= op_i;
			mode_q <= mode_i;
			pc_q <= pc_o;
			regs_q <= {acc_o, x_o, y_o};
		end
	end
	////////////////////////////////////////////////////////////
	no_fetch_a: assert property (
		take && mode_i inside {mode_implied, mode_accumulator} && !(op_i inside
		{op_pull_accumulator, op_pull_flags, op_subroutine_return, op_interrupt_return})
		|-> !mem_req_o throughout ##[1:3] done_o) else $error("one-byte form used memory");
	first_fetch_a: assert property (
		take && !(mode_i inside {mode_implied, mode_accumulator})
		|=> mem_req_o && !mem_we_o && mem_addr_o == pc_q) else $error("first fetch wrong");
	zp_page_a: assert property (
		busy_o && mem_req_o && mode_q inside {mode_zero_page, mode_zero_page_x, mode_zero_page_y}
		|-> mem_addr_o == pc_q || mem_addr_o[15:8] == 8'h00) else $error("left page zero");
	req_hold_a: assert property ($fell(mem_req_o) |-> $past(mem_ready_i, 2))
		else $error("request dropped early");
	addr_hold_a: assert property (
		mem_req_o && $past(mem_req_o) && $changed(mem_addr_o) |-> $past(mem_ready_i, 2))
		else $error("address moved early");
	write_kind_a: assert property (
		mem_req_o && mem_we_o |-> op_q inside {op_store_accumulator, op_store_x, op_store_y,
		op_shift_left, op_shift_right, op_rotate_left, op_rotate_right,
		op_memory_plus_one, op_memory_minus_one}) else $error("unexpected write");
	store_data_a: assert property (
		mem_req_o && mem_we_o && op_q inside {op_store_accumulator, op_store_x, op_store_y}
		|-> mem_wdata_o == (op_q == op_store_x ? x_o : op_q == op_store_y ? y_o : acc_o))
		else $error("store data wrong");
	keep_cmp_a: assert property (
		done_o && op_q inside {op_compare_acc, op_compare_x, op_compare_y}
		|=> {acc_o, x_o, y_o} == regs_q) else $error("compare altered a register");
	freeze_hold_a: assert property (!clk_en_i |=> $stable(pc_o) && $stable(mem_req_o) &&
		$stable(mem_addr_o)) else $error("state moved while disabled");
	cover property (take && mode_i == mode_absolute_y);
	cover property (mem_req_o && mem_we_o);
	cover property (!clk_en_i && mem_req_o);
endmodule
bind operand_address_generator opgen_asserts chk (.core_clk_i, .reset_i, .clk_en_i, .start_i,
	.op_i, .mode_i, .mem_ready_i, .busy_o, .done_o, .mem_req_o, .mem_we_o, .mem_addr_o,
	.mem_wdata_o, .pc_o, .acc_o, .x_o, .y_o);
`default_nettype wire

// *** tb/opgen_mem_model.sv ***
// memory partner answering the level request handshake
`timescale 1ns/10ps
`default_nettype none
module opgen_mem_model (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [3:0] lat_i,
	output logic [7:0] rdata_o,
	output logic ready_o
);
	logic [7:0] mem [0:65535];
	logic [16:0] held;
	logic [3:0] wait_cnt;
	// ready stands until the request drops or moves; data scrambles when not valid
	always @(posedge core_clk_i) begin
		rdata_o <= ~rdata_o;
		if (reset_i) begin
			ready_o <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (ready_o) begin
			if (!req_i || {we_i, addr_i} != held) ready_o <= 1'b0;
		end else if (req_i && wait_cnt >= lat_i) begin
			ready_o <= 1'b1;
			wait_cnt <= 4'h0;
			held <= {we_i, addr_i};
			if (we_i) mem[addr_i] <= wdata_i;
			else rdata_o <= mem[addr_i];
		end else if (req_i) wait_cnt <= wait_cnt + 4'h1;
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import opgen_pkg::*;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic start_i = 1'b0;
	op_t op_i = op_idle_instruction;
	addr_mode_t mode_i = mode_implied;
	logic [7:0] branch_offset_i = 8'h00;
	logic [3:0] lat = 4'h0;
	logic [7:0] mem_rdata_i, mem_wdata_o, acc_o, x_o, y_o, sp_o, flags_o;
	logic mem_ready_i, busy_o, done_o, mem_req_o, mem_we_o;
	logic [15:0] mem_addr_o, pc_o, ea_o, p;
	int errors = 0;
	int checked = 0;
	always #5 core_clk_i = ~core_clk_i;
	operand_address_generator dut (.core_clk_i, .reset_i, .clk_en_i, .start_i, .op_i, .mode_i,
		.branch_offset_i, .mem_rdata_i, .mem_ready_i, .busy_o, .done_o, .mem_req_o, .mem_we_o,
		.mem_addr_o, .mem_wdata_o, .pc_o, .ea_o, .acc_o, .x_o, .y_o, .sp_o, .flags_o);
	opgen_mem_model mdl (.core_clk_i, .reset_i, .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .lat_i(lat), .rdata_o(mem_rdata_i),
		.ready_o(mem_ready_i));
	////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// one instruction; fz stalls the clock enable for three cycles mid-flight
	task automatic run(input op_t o, input addr_mode_t m, input logic fz);
		int n;
		@(posedge core_clk_i);
		#1;
		start_i = 1'b1;
		op_i = o;
		mode_i = m;
		@(posedge core_clk_i);
		#1;
		start_i = 1'b0;
		if (fz) begin
			clk_en_i = 1'b0;
			repeat (3) @(posedge core_clk_i);
			#1;
			clk_en_i = 1'b1;
		end
		n = 0;
		while (done_o !== 1'b1 && n < 400) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		if (n >= 400) check(16'h0001, 16'h0000);
	endtask
	task automatic imm(input op_t o, input logic [7:0] v);
		p = pc_o;
		mdl.mem[p] = v;
		run(o, mode_immediate, 1'b0);
		check(pc_o, p + 16'h0002);
	endtask
	// data byte differs from every neighbour, so a wrong address shows in acc
	task automatic load_at(input addr_mode_t m, input logic [15:0] base, ea, len);
		p = pc_o;
		mdl.mem[p] = base[7:0];
		mdl.mem[p + 16'h0001] = base[15:8];
		mdl.mem[ea] = ea[7:0] ^ 8'h5A;
		run(op_load_accumulator, m, 1'b0);
		check(ea_o, ea);
		check(acc_o, ea[7:0] ^ 8'h5A);
		check(pc_o, p + len);
	endtask
	task automatic t_reset();
		check({sp_o, flags_o}, 16'hFD24);
		check(pc_o, 16'h0000);
	endtask
	task automatic t_loads();
		imm(op_load_accumulator, 8'h80);
		check(acc_o, 8'h80);
		imm(op_load_x, 8'hC0);
		imm(op_load_y, 8'hD0);
		check({x_o, y_o}, 16'hC0D0);
		lat = 4'h5;
		load_at(mode_absolute, 16'hFFFE, 16'hFFFE, 16'h0003);
		lat = 4'h0;
		load_at(mode_zero_page, 16'h7781, 16'h0081, 16'h0002);
		load_at(mode_zero_page_x, 16'h77F0, 16'h00B0, 16'h0002);
		load_at(mode_zero_page_y, 16'h77F0, 16'h00C0, 16'h0002);
		load_at(mode_absolute_x, 16'h10F0, 16'h11B0, 16'h0003);
		load_at(mode_absolute_y, 16'h12F0, 16'h13C0, 16'h0003);
	endtask
	task automatic t_regs();
		op_t s [10] = '{op_x_plus_one, op_y_minus_one, op_copy_x_to_acc, op_copy_acc_to_y,
			op_x_minus_one, op_copy_x_to_sp, op_y_plus_one, op_copy_y_to_acc,
			op_copy_acc_to_x, op_copy_sp_to_x};
		logic [31:0] w [10] = '{32'h9AC1D0FD, 32'h9AC1CFFD, 32'hC1C1CFFD, 32'hC1C1C1FD,
			32'hC1C0C1FD, 32'hC1C0C1C0, 32'hC1C0C2C0, 32'hC2C0C2C0, 32'hC2C2C2C0,
			32'hC2C0C2C0};
		foreach (s[i]) begin
			p = pc_o;
			run(s[i], mode_implied, 1'b0);
			check({acc_o, x_o}, w[i][31:16]);
			check({y_o, sp_o}, w[i][15:0]);
			check(pc_o, p + 16'h0001);
		end
	endtask
	task automatic t_flags();
		op_t s [6] = '{op_set_carry, op_clear_carry, op_set_decimal, op_clear_decimal,
			op_set_irq_mask, op_clear_irq_mask};
		int b [6] = '{0, 0, 3, 3, 2, 2};
		foreach (s[i]) begin
			run(s[i], mode_implied, 1'b0);
			check(flags_o[b[i]], {15'h0000, ~i[0]});
		end
	endtask
	task automatic t_arith();
		imm(op_load_accumulator, 8'h50);
		imm(op_add_with_carry, 8'h50);
		check({acc_o, flags_o[6], flags_o[0]}, {8'hA0, 2'b10});
		run(op_clear_overflow, mode_implied, 1'b0);
		check(flags_o[6], 1'b0);
		imm(op_subtract_with_borrow, 8'h10);
		check({acc_o, flags_o[0]}, {8'h8F, 1'b1});
		imm(op_compare_acc, 8'h8F);
		check({acc_o, flags_o[1]}, {8'h8F, 1'b1});
		p = pc_o;
		run(op_shift_left, mode_accumulator, 1'b0);
		check({acc_o, flags_o[0]}, {8'h1E, 1'b1});
		check(pc_o, p + 16'h0001);
	endtask
	task automatic t_store();
		lat = 4'h3;
		mdl.mem[pc_o] = 8'h90;
		run(op_store_accumulator, mode_zero_page, 1'b1);
		check(mdl.mem[16'h0090], 8'h1E);
		mdl.mem[pc_o] = 8'h45;
		mdl.mem[pc_o + 16'h0001] = 8'h23;
		run(op_store_y, mode_absolute, 1'b0);
		check(mdl.mem[16'h2345], 8'hC2);
	endtask
	// branches, stack pointer movement and an absolute jump
	task automatic t_flow();
		branch_offset_i = 8'h10;
		p = pc_o;
		run(op_branch_if_carry_set, mode_implied, 1'b0);
		check(pc_o, p + 16'h0011);
		p = pc_o;
		run(op_branch_if_carry_clear, mode_implied, 1'b0);
		check(pc_o, p + 16'h0001);
		run(op_push_accumulator, mode_implied, 1'b0);
		check(sp_o, 8'hBF);
		run(op_pull_accumulator, mode_implied, 1'b0);
		check(sp_o, 8'hC0);
		mdl.mem[pc_o] = 8'h00;
		mdl.mem[pc_o + 16'h0001] = 8'h40;
		run(op_jump, mode_absolute, 1'b0);
		check(pc_o, 16'h4000);
	endtask
	task automatic print_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// whole sequence needs a few hundred cycles; the watchdog allows 5000 cycles, far more
	initial begin
		#50000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		#1;
		reset_i = 1'b0;
		t_reset();
		t_loads();
		t_regs();
		t_flags();
		t_arith();
		t_store();
		t_flow();
		print_verdict();
	end
endmodule
`default_nettype wire
